// ### common/rftxf_pkg.sv
//==============================================================================
// Behaviour
// R01: crc_result_low reads low CRC byte at 0Dh, valid only when checksum_done_flag is one.
// R02: crc_result_high reads high CRC byte at 0Eh, valid only when checksum_done_flag is one.
// R03: for 8-bit CRC the high result byte is undefined; host must not rely on it.
// R04: receive_bit_offset bits 6..4 place first received bit; later bits fill higher positions.
// R05: offset 111 puts first bit at position 7, second at next byte position 0.
// R06: receive_bit_offset clears to zero automatically when a reception completes.
// R07: final_byte_bit_count bits 2..0 is bits sent of last byte; 000 sends all.
// R08: final_byte_bit_count clears to zero automatically after transmission finishes.
// R09: modulator_input_select bits 6..5: 00 low, 01 high, 10 encoder, 11 reserved.
// R10: force_full_depth_keying bit 4 gives 100 % keying regardless of modulation conductance.
// R11: second_driver_invert bit 3 makes driver b output the inverted carrier.
// R12: second_driver_plain_carrier bit 2 set gives unmodulated carrier on driver b.
// R13: second_driver_rf_on bit 1 set gives modulated carrier on driver b, else constant.
// R14: first_driver_rf_on bit 0 set gives modulated carrier on driver a, else constant.
// R15: carrier_conductance_value bits 5..0 set drive conductance of both antenna outputs.
// R16: modulation_conductance_value bits 5..0 set conductance applied while modulating.
// R17: host keeps bits 7..6 of both conductance registers at their reset value.
// R18: transmit_control reads 48h after reset.
// R19: bit_frame_adjust reads 00h after reset.
// R20: reading CRC result bytes has no side effect on coprocessor or flags.
//==============================================================================
package rftxf_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] CRC_RESULT_LOW_ADDR      = 8'h0D;
  localparam logic [7:0] CRC_RESULT_HIGH_ADDR     = 8'h0E;
  localparam logic [7:0] BIT_FRAME_ADJUST_ADDR    = 8'h0F;
  localparam logic [7:0] TRANSMIT_CONTROL_ADDR    = 8'h11;
  localparam logic [7:0] CARRIER_CONDUCTANCE_ADDR = 8'h12;
  localparam logic [7:0] MOD_CONDUCTANCE_ADDR     = 8'h13;

  // ==========================================================================
  // reset values
  localparam logic [7:0] BIT_FRAME_ADJUST_RESET    = 8'h00;
  localparam logic [7:0] TRANSMIT_CONTROL_RESET    = 8'h48;
  localparam logic [7:0] CARRIER_CONDUCTANCE_RESET = 8'h3F;
  localparam logic [7:0] MOD_CONDUCTANCE_RESET     = 8'h05;
  localparam logic [7:0] UNMAPPED_READ_VALUE       = 8'h00;

  // ==========================================================================
  // field positions
  localparam int RX_OFFSET_LSB     = 4;
  localparam int RX_OFFSET_MSB     = 6;
  localparam int TX_LAST_LSB       = 0;
  localparam int TX_LAST_MSB       = 2;
  localparam int MOD_SELECT_LSB    = 5;
  localparam int MOD_SELECT_MSB    = 6;
  localparam int FORCE_FULL_BIT    = 4;
  localparam int B_INVERT_BIT      = 3;
  localparam int B_PLAIN_BIT       = 2;
  localparam int B_RF_ON_BIT       = 1;
  localparam int A_RF_ON_BIT       = 0;
  localparam int CONDUCTANCE_MSB   = 5;
  localparam logic [7:0] BIT_FRAME_USED_MASK = 8'h77;

  // ==========================================================================
  // modulator input sources
  typedef enum logic [1:0] {
    MOD_SRC_LOW      = 2'h0,
    MOD_SRC_HIGH     = 2'h1,
    MOD_SRC_ENCODER  = 2'h2,
    MOD_SRC_RESERVED = 2'h3
  } rftxf_mod_src_type;

  // level held by a driver whose rf output is off
  localparam logic DRIVER_IDLE_LEVEL = 1'b0;

endpackage

// ### design/rftxf_registers.sv
`timescale 1ns/1ps
module rftxf_registers
  import rftxf_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int CONDUCTANCE_WIDTH = 6
)
(
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         arst_n,
  // parallel register port
  input  wire logic [ADDR_WIDTH-1:0]        regAddr,
  input  wire logic                         regWrite,
  input  wire logic                         regRead,
  input  wire logic [7:0]                   regWriteData,
  output logic      [7:0]                   regReadData,
  // crc coprocessor
  input  wire logic [15:0]                  crcResult,
  input  wire logic                         checksumDoneFlag,
  // framer
  input  wire logic                         receptionDone,
  input  wire logic                         transmissionDone,
  output logic      [2:0]                   receiveBitOffset,
  output logic      [2:0]                   finalByteBitCount,
  // encoder and carrier
  input  wire logic                         encoderOutput,
  input  wire logic                         carrierClock,
  // antenna drivers
  output logic                              modulatorInput,
  output logic                              forceFullDepthKeying,
  output logic                              antennaDriverA,
  output logic                              antennaDriverB,
  output logic      [CONDUCTANCE_WIDTH-1:0] conductanceDriverA,
  output logic      [CONDUCTANCE_WIDTH-1:0] conductanceDriverB
);

  // ==========================================================================
  // elaboration checks
  if (ADDR_WIDTH < 5 || ADDR_WIDTH > 8)
  begin : gAddrCheck
    $error("ADDR_WIDTH must lie between 5 and 8");
  end
  if (CONDUCTANCE_WIDTH != CONDUCTANCE_MSB + 1)
  begin : gCondCheck
    $error("CONDUCTANCE_WIDTH must match the conductance field");
  end

  // ==========================================================================
  // address decode
  logic [7:0] fullAddr;
  logic       hitLow;
  logic       hitHigh;
  logic       hitFrame;
  logic       hitControl;
  logic       hitCarrier;
  logic       hitMod;

  // a narrow address bus is zero-extended before decode
  assign fullAddr   = 8'(regAddr);
  assign hitLow     = (fullAddr == CRC_RESULT_LOW_ADDR);
  assign hitHigh    = (fullAddr == CRC_RESULT_HIGH_ADDR);
  assign hitFrame   = (fullAddr == BIT_FRAME_ADJUST_ADDR);
  assign hitControl = (fullAddr == TRANSMIT_CONTROL_ADDR);
  assign hitCarrier = (fullAddr == CARRIER_CONDUCTANCE_ADDR);
  assign hitMod     = (fullAddr == MOD_CONDUCTANCE_ADDR);

  // ==========================================================================
  // register state
  logic [7:0] bitFrameAdjust;
  logic [7:0] transmitControl;
  logic [7:0] carrierDriveConductance;
  logic [7:0] modulationDriveConductance;
  logic [7:0] next_bitFrameAdjust;
  logic [7:0] next_transmitControl;
  logic [7:0] next_carrierDriveConductance;
  logic [7:0] next_modulationDriveConductance;

  always_comb
  begin
    next_bitFrameAdjust             = bitFrameAdjust;
    next_transmitControl            = transmitControl;
    next_carrierDriveConductance    = carrierDriveConductance;
    next_modulationDriveConductance = modulationDriveConductance;
    // framer completions clear their fields; a host write in the same cycle wins
    if (receptionDone)
    begin
      next_bitFrameAdjust[RX_OFFSET_MSB:RX_OFFSET_LSB] = 3'h0; // see R06
    end
    if (transmissionDone)
    begin
      next_bitFrameAdjust[TX_LAST_MSB:TX_LAST_LSB] = 3'h0; // see R08
    end
    // reserved bits 7 and 3 always read back as zero
    if (regWrite && hitFrame)
    begin
      next_bitFrameAdjust = regWriteData & BIT_FRAME_USED_MASK;
    end
    // bit 7 is stored as written; software keeps it at zero
    if (regWrite && hitControl)
    begin
      next_transmitControl = regWriteData;
    end
    // upper bits stored as written; software keeps them at reset value
    if (regWrite && hitCarrier)
    begin
      next_carrierDriveConductance = regWriteData; // see R17
    end
    if (regWrite && hitMod)
    begin
      next_modulationDriveConductance = regWriteData; // see R17
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bitFrameAdjust             <= BIT_FRAME_ADJUST_RESET; // see R19
      transmitControl            <= TRANSMIT_CONTROL_RESET; // see R18
      carrierDriveConductance    <= CARRIER_CONDUCTANCE_RESET;
      modulationDriveConductance <= MOD_CONDUCTANCE_RESET;
    end
    else
    begin
      bitFrameAdjust             <= next_bitFrameAdjust;
      transmitControl            <= next_transmitControl;
      carrierDriveConductance    <= next_carrierDriveConductance;
      modulationDriveConductance <= next_modulationDriveConductance;
    end
  end

  // ==========================================================================
  // read path
  logic [7:0] readValue;
  logic [7:0] next_regReadData;

  always_comb
  begin
    // unmapped addresses read as zero
    readValue = UNMAPPED_READ_VALUE;
    // crc bytes are plain views: reading never touches the coprocessor
    if (hitLow)
    begin
      readValue = crcResult[7:0]; // see R01, R20
    end
    else if (hitHigh)
    begin
      readValue = crcResult[15:8]; // see R02, R03, R20
    end
    else if (hitFrame)
    begin
      readValue = bitFrameAdjust;
    end
    else if (hitControl)
    begin
      readValue = transmitControl;
    end
    else if (hitCarrier)
    begin
      readValue = carrierDriveConductance;
    end
    else if (hitMod)
    begin
      readValue = modulationDriveConductance;
    end
    // a read and a write in one cycle return the old register value
    next_regReadData = regReadData;
    if (regRead)
    begin
      next_regReadData = readValue;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regReadData <= UNMAPPED_READ_VALUE;
    end
    else
    begin
      regReadData <= next_regReadData;
    end
  end

  // ==========================================================================
  // transmitter control decode
  rftxf_mod_src_type modSelect;
  logic              forceFull;
  logic              bInvert;
  logic              bPlain;
  logic              bRfOn;
  logic              aRfOn;

  assign modSelect = rftxf_mod_src_type'(transmitControl[MOD_SELECT_MSB:MOD_SELECT_LSB]);
  assign forceFull = transmitControl[FORCE_FULL_BIT];
  assign bInvert   = transmitControl[B_INVERT_BIT];
  assign bPlain    = transmitControl[B_PLAIN_BIT];
  assign bRfOn     = transmitControl[B_RF_ON_BIT];
  assign aRfOn     = transmitControl[A_RF_ON_BIT];

  // ==========================================================================
  // driver stage
  logic                         modSource;
  logic                         carrierB;
  logic                         next_modulatorInput;
  logic                         next_forceFullDepthKeying;
  logic                         next_antennaDriverA;
  logic                         next_antennaDriverB;
  logic [2:0]                   next_receiveBitOffset;
  logic [2:0]                   next_finalByteBitCount;
  logic [CONDUCTANCE_WIDTH-1:0] next_conductanceDriverA;
  logic [CONDUCTANCE_WIDTH-1:0] next_conductanceDriverB;
  logic [CONDUCTANCE_WIDTH-1:0] carrierConductanceValue;
  logic [CONDUCTANCE_WIDTH-1:0] modulationConductanceValue;

  // only the low six bits reach the drivers
  assign carrierConductanceValue    = carrierDriveConductance[CONDUCTANCE_MSB:0];
  assign modulationConductanceValue = modulationDriveConductance[CONDUCTANCE_MSB:0];

  always_comb
  begin
    unique case (modSelect)
      MOD_SRC_LOW:      modSource = 1'b0; // see R09
      MOD_SRC_HIGH:     modSource = 1'b1; // see R09
      MOD_SRC_ENCODER:  modSource = encoderOutput; // see R09
      // reserved code keeps the modulator quiet
      MOD_SRC_RESERVED: modSource = 1'b0;
    endcase
    // inversion acts on the carrier before any keying
    carrierB = carrierClock ^ bInvert; // see R11
    next_modulatorInput       = modSource;
    next_forceFullDepthKeying = forceFull;
    // driver a: carrier keyed by modulation, or held constant when off
    next_antennaDriverA     = DRIVER_IDLE_LEVEL; // see R14
    next_conductanceDriverA = carrierConductanceValue; // see R15
    if (aRfOn)
    begin
      next_antennaDriverA = carrierClock; // see R14
      if (modSource)
      begin
        next_conductanceDriverA = modulationConductanceValue; // see R16
        if (forceFull)
        begin
          // full-depth keying removes the carrier while modulating
          next_antennaDriverA = DRIVER_IDLE_LEVEL; // see R10
        end
      end
    end
    // driver b: like a, but a plain carrier ignores the modulation
    next_antennaDriverB     = DRIVER_IDLE_LEVEL; // see R13
    next_conductanceDriverB = carrierConductanceValue; // see R15
    if (bRfOn)
    begin
      next_antennaDriverB = carrierB; // see R13
      if (modSource && !bPlain)
      begin
        next_conductanceDriverB = modulationConductanceValue; // see R12, R16
        if (forceFull)
        begin
          next_antennaDriverB = DRIVER_IDLE_LEVEL; // see R10
        end
      end
    end
    // framer alignment and last-byte length
    next_receiveBitOffset  = bitFrameAdjust[RX_OFFSET_MSB:RX_OFFSET_LSB]; // see R04, R05
    next_finalByteBitCount = bitFrameAdjust[TX_LAST_MSB:TX_LAST_LSB]; // see R07
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modulatorInput       <= 1'b0;
      forceFullDepthKeying <= 1'b0;
      antennaDriverA       <= DRIVER_IDLE_LEVEL;
      antennaDriverB       <= DRIVER_IDLE_LEVEL;
      conductanceDriverA   <= CARRIER_CONDUCTANCE_RESET[CONDUCTANCE_MSB:0];
      conductanceDriverB   <= CARRIER_CONDUCTANCE_RESET[CONDUCTANCE_MSB:0];
      receiveBitOffset     <= 3'h0;
      finalByteBitCount    <= 3'h0;
    end
    else
    begin
      // every driver output lags its inputs by one clock
      modulatorInput       <= next_modulatorInput;
      forceFullDepthKeying <= next_forceFullDepthKeying;
      antennaDriverA       <= next_antennaDriverA;
      antennaDriverB       <= next_antennaDriverB;
      conductanceDriverA   <= next_conductanceDriverA;
      conductanceDriverB   <= next_conductanceDriverB;
      receiveBitOffset     <= next_receiveBitOffset;
      finalByteBitCount    <= next_finalByteBitCount;
    end
  end

  // checksumDoneFlag only qualifies the crc bytes for software; no logic here
  logic unusedDone;
  assign unusedDone = checksumDoneFlag;

endmodule

// ### test/rftxf_host_model.sv
`timescale 1ns/1ps
module rftxf_host_model
  import rftxf_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regWriteData,
  input  wire logic [7:0] regReadData
);
  initial regAddr = 8'h00;
  initial regWrite = 1'b0;
  initial regRead = 1'b0;
  initial regWriteData = 8'h00;
  // idle bus shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == CARRIER_CONDUCTANCE_ADDR || a == MOD_CONDUCTANCE_ADDR)
      v[7:6] = 2'h0;
    @(posedge clk_sys);
    regAddr <= a;
    regWriteData <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWriteData <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regReadData;
  endtask
endmodule

// ### test/rftxf_registers_asserts.sv
`timescale 1ns/1ps
module rftxf_registers_asserts
  import rftxf_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int CONDUCTANCE_WIDTH = 6
)
(
  // clock and reset
  input wire logic                         clk_sys,
  input wire logic                         arst_n,
  // register port
  input wire logic [ADDR_WIDTH-1:0]        regAddr,
  input wire logic                         regWrite,
  input wire logic                         regRead,
  input wire logic [7:0]                   regWriteData,
  input wire logic [7:0]                   regReadData,
  // coprocessor and framer
  input wire logic [15:0]                  crcResult,
  input wire logic                         checksumDoneFlag,
  input wire logic                         receptionDone,
  input wire logic                         transmissionDone,
  input wire logic [2:0]                   receiveBitOffset,
  input wire logic [2:0]                   finalByteBitCount,
  // drivers
  input wire logic                         encoderOutput,
  input wire logic                         carrierClock,
  input wire logic                         modulatorInput,
  input wire logic                         forceFullDepthKeying,
  input wire logic                         antennaDriverA,
  input wire logic                         antennaDriverB,
  input wire logic [CONDUCTANCE_WIDTH-1:0] conductanceDriverA,
  input wire logic [CONDUCTANCE_WIDTH-1:0] conductanceDriverB
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic       wrFrame;
  logic       wrTx;
  logic [7:0] crcLo;
  logic [7:0] crcHi;
  assign wrFrame = regWrite && regAddr == BIT_FRAME_ADJUST_ADDR;
  assign wrTx    = regWrite && regAddr == TRANSMIT_CONTROL_ADDR;
  assign crcLo   = crcResult[7:0];
  assign crcHi   = crcResult[15:8];
  sequence crcRead(logic [7:0] a);
    regRead && regAddr == a;
  endsequence
  sequence doneTaken(logic done);
    done && !wrFrame;
  endsequence
  // ==========================================================================
  // checks
  crc_low_a: assert property (
    crcRead(CRC_RESULT_LOW_ADDR) |=> regReadData == $past(crcLo)) else $error("crc low wrong");
  crc_high_a: assert property (
    crcRead(CRC_RESULT_HIGH_ADDR) |=> regReadData == $past(crcHi)) else $error("crc high wrong");
  read_hold_a: assert property (
    !regRead |=> $stable(regReadData)) else $error("read data moved without read");
  offset_last_a: assert property (
    wrFrame && regWriteData[6:4] == 3'h7 |-> ##2 receiveBitOffset == 3'h7)
    else $error("offset not loaded");
  offset_clear_a: assert property (
    doneTaken(receptionDone) |-> ##2 receiveBitOffset == 3'h0) else $error("offset not cleared");
  count_clear_a: assert property (
    doneTaken(transmissionDone) |-> ##2 finalByteBitCount == 3'h0) else $error("count not cleared");
  force_copy_a: assert property (
    wrTx |-> ##2 forceFullDepthKeying == $past(regWriteData[4], 2)) else $error("force bit wrong");
  mod_fixed_a: assert property (
    wrTx && !regWriteData[6] |-> ##2 modulatorInput == $past(regWriteData[5], 2))
    else $error("modulator level wrong");
  driver_off_a: assert property (
    wrTx && regWriteData[1:0] == 2'h0 |-> ##2 !antennaDriverA && !antennaDriverB)
    else $error("driver not idle");
  b_invert_a: assert property (
    wrTx && regWriteData[3:1] == 3'h7 |-> ##2 antennaDriverB != $past(carrierClock))
    else $error("driver b not inverted");
endmodule

bind rftxf_registers rftxf_registers_asserts #(
  .ADDR_WIDTH(ADDR_WIDTH),
  .CONDUCTANCE_WIDTH(CONDUCTANCE_WIDTH)
) chk (.clk_sys, .arst_n, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData,
  .crcResult, .checksumDoneFlag, .receptionDone, .transmissionDone, .receiveBitOffset,
  .finalByteBitCount, .encoderOutput, .carrierClock, .modulatorInput, .forceFullDepthKeying,
  .antennaDriverA, .antennaDriverB, .conductanceDriverA, .conductanceDriverB);

// ### test/tb_rf_tx_framing_registers.sv
`timescale 1ns/1ps
module tb_rf_tx_framing_registers;
  import rftxf_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  regAddr, regWriteData, regReadData;
  logic        regWrite, regRead, modulatorInput, forceFullDepthKeying;
  logic        antennaDriverA, antennaDriverB;
  logic        checksumDoneFlag = 1'b0, receptionDone = 1'b0, transmissionDone = 1'b0;
  logic        encoderOutput = 1'b0, carrierClock = 1'b0;
  logic [15:0] crcResult = 16'h0000;
  logic [2:0]  receiveBitOffset, finalByteBitCount;
  logic [5:0]  conductanceDriverA, conductanceDriverB;
  int          n_mismatch = 0;
  int          checks = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) carrierClock <= ~carrierClock;
  rftxf_registers dut (.clk_sys, .arst_n, .regAddr, .regWrite, .regRead, .regWriteData,
    .regReadData, .crcResult, .checksumDoneFlag, .receptionDone, .transmissionDone,
    .receiveBitOffset, .finalByteBitCount, .encoderOutput, .carrierClock, .modulatorInput,
    .forceFullDepthKeying, .antennaDriverA, .antennaDriverB, .conductanceDriverA,
    .conductanceDriverB);
  rftxf_host_model host (.clk_sys, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData);
  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    rdChk(BIT_FRAME_ADJUST_ADDR, 8'h00);
    rdChk(TRANSMIT_CONTROL_ADDR, 8'h48);
    rdChk(CARRIER_CONDUCTANCE_ADDR, 8'h3F);
    rdChk(MOD_CONDUCTANCE_ADDR, 8'h05);
    rdChk(8'h10, 8'h00);
    chk({6'h00, antennaDriverA, antennaDriverB}, 8'h00);
  endtask
  task automatic t_crc;
    @(posedge clk_sys);
    crcResult <= 16'hA55A;
    checksumDoneFlag <= 1'b1;
    rdChk(CRC_RESULT_LOW_ADDR, 8'h5A);
    rdChk(CRC_RESULT_HIGH_ADDR, 8'hA5);
    rdChk(CRC_RESULT_LOW_ADDR, 8'h5A);
    host.wr(CRC_RESULT_LOW_ADDR, 8'h00);
    rdChk(CRC_RESULT_LOW_ADDR, 8'h5A);
  endtask
  task automatic t_frame;
    host.wr(BIT_FRAME_ADJUST_ADDR, 8'hFF);
    rdChk(BIT_FRAME_ADJUST_ADDR, 8'h77);
    chk({5'h00, receiveBitOffset}, 8'h07);
    chk({5'h00, finalByteBitCount}, 8'h07);
    @(posedge clk_sys);
    receptionDone <= 1'b1;
    @(posedge clk_sys);
    receptionDone <= 1'b0;
    rdChk(BIT_FRAME_ADJUST_ADDR, 8'h07);
    @(posedge clk_sys);
    transmissionDone <= 1'b1;
    @(posedge clk_sys);
    transmissionDone <= 1'b0;
    rdChk(BIT_FRAME_ADJUST_ADDR, 8'h00);
    chk({2'h0, receiveBitOffset, finalByteBitCount}, 8'h00);
  endtask
  task automatic t_tx;
    @(posedge clk_sys);
    encoderOutput <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      host.wr(TRANSMIT_CONTROL_ADDR, {1'b0, 2'(i), 5'h00});
      tick;
      chk({7'h00, modulatorInput}, {7'h00, i == 1 || i == 2});
    end
    @(posedge clk_sys);
    encoderOutput <= 1'b0;
    host.wr(TRANSMIT_CONTROL_ADDR, 8'h40);
    tick;
    chk({7'h00, modulatorInput}, 8'h00);
    host.wr(CARRIER_CONDUCTANCE_ADDR, 8'h2A);
    host.wr(MOD_CONDUCTANCE_ADDR, 8'h11);
    host.wr(TRANSMIT_CONTROL_ADDR, 8'h3F);
    tick;
    chk({7'h00, forceFullDepthKeying}, 8'h01);
    chk({7'h00, antennaDriverA}, 8'h00);
    chk({2'h0, conductanceDriverA}, 8'h11);
    chk({2'h0, conductanceDriverB}, 8'h2A);
    host.wr(TRANSMIT_CONTROL_ADDR, 8'h3B);
    tick;
    chk({2'h0, conductanceDriverB}, 8'h11);
    chk({7'h00, antennaDriverB}, 8'h00);
    host.wr(TRANSMIT_CONTROL_ADDR, 8'h0F);
    tick;
    chk({2'h0, conductanceDriverA}, 8'h2A);
    repeat (4)
    begin
      tick;
      chk({7'h00, antennaDriverA ^ antennaDriverB}, 8'h01);
      chk({7'h00, antennaDriverA}, {7'h00, ~carrierClock});
    end
    host.wr(TRANSMIT_CONTROL_ADDR, 8'h08);
    repeat (4)
    begin
      tick;
      chk({6'h00, antennaDriverA, antennaDriverB}, 8'h00);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    t_crc;
    t_frame;
    t_tx;
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    end_sim;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    end_sim;
  end
endmodule
